/* design/sram_write_host.sv */
// Host controller that writes and reads an asynchronous 64K by 4 static RAM.
`timescale 1ns/1ns
// How it works
// - A write stores only while select and write strobe are both low, so the host makes that overlap.
// - Each write cycle holds the address for at least the write cycle time.
// - The address is steady for at least the address-to-end time before the write ends.
// - Write data is on the bus at least the data lead time before the write strobe rises.
// - In a select-ended write, select stays low at least the select-low time before the end.
// - The host avoids driving the data lines while the memory may drive them.
// - The write strobe stays high throughout every read.
module sram_write_host
  import sram_host_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input  wire logic              CLK,
  input  wire logic              RST,
  // Request stream: write flag, address and data.
  input  wire logic              REQ_VALID,
  output logic                   REQ_READY,
  input  wire logic              REQ_WRITE,
  input  wire logic [ADDR_W-1:0] REQ_ADDR,
  input  wire logic [DATA_W-1:0] REQ_WDATA,
  // Read answer.
  output logic                   RD_VALID,
  output logic      [DATA_W-1:0] RD_DATA,
  // Memory pins.
  output logic      [ADDR_W-1:0] MEM_ADDR,
  output logic                   MEM_SEL_N,
  output logic                   MEM_OUTEN_N,
  output logic                   MEM_WR_N,
  output logic      [DATA_W-1:0] MEM_DQ_OUT,
  output logic                   MEM_DQ_OE,
  input  wire logic [DATA_W-1:0] MEM_DQ_IN
);
  localparam int FW = 1 + ADDR_W + DATA_W;

  initial begin
    if (WRITE_LOW_CYC < DATA_LEAD_CYC || WRITE_LOW_CYC < SELECT_LOW_CYC
        || WRITE_LOW_CYC + 1 >= (1 << CNT_W)) begin
      $error("write timing does not fit the step counter");
    end
    // The read counter runs to the cycle time plus two settling edges.
    if (CYCLE_CYC + 3 >= (1 << CNT_W) || TURN_CYC + 1 >= (1 << CNT_W)) begin
      $error("read timing does not fit the step counter");
    end
  end

  // Request FIFO between the user and the sequencer.
  logic          f_valid;
  logic          f_ready;
  logic [FW-1:0] f_data;

  sync_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) req_fifo (
    .clk       (CLK),
    .rst       (RST),
    .in_valid  (REQ_VALID),
    .in_ready  (REQ_READY),
    .in_data   ({REQ_WRITE, REQ_ADDR, REQ_WDATA}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // Two-flop synchroniser on the data pins coming from the memory.
  logic [DATA_W-1:0] dq_meta_reg;
  logic [DATA_W-1:0] dq_sync_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      dq_meta_reg <= '0;
      dq_sync_reg <= '0;
    end else begin
      dq_meta_reg <= MEM_DQ_IN;
      dq_sync_reg <= dq_meta_reg;
    end
  end

  // Sequencer state.
  host_state_t       state_reg;
  host_state_t       state_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] wdata_next;
  logic              sel_n_reg;
  logic              sel_n_next;
  logic              wr_n_reg;
  logic              wr_n_next;
  logic              outen_n_reg;
  logic              outen_n_next;
  logic              oe_reg;
  logic              oe_next;
  logic              rdv_reg;
  logic              rdv_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // Next-state logic: a write asserts select and strobe together after one setup cycle.
  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    sel_n_next   = sel_n_reg;
    wr_n_next    = wr_n_reg;
    outen_n_next = outen_n_reg;
    oe_next      = oe_reg;
    rdv_next     = 1'b0;
    rdata_next   = rdata_reg;
    f_ready      = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (f_valid) begin
          f_ready    = 1'b1;
          addr_next  = f_data[DATA_W +: ADDR_W];
          wdata_next = f_data[DATA_W-1:0];
          cnt_next   = '0;
          if (f_data[FW-1]) begin
            // Enable is already high, so the memory is not driving the bus.
            oe_next    = 1'b1;
            state_next = ST_SETUP;
          end else begin
            wr_n_next    = 1'b1;
            sel_n_next   = 1'b0;
            outen_n_next = 1'b0;
            state_next   = ST_RD_TURN;
          end
        end
      end
      ST_SETUP: begin
        sel_n_next = 1'b0;
        wr_n_next  = 1'b0;
        state_next = ST_STROBE;
      end
      ST_STROBE: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(WRITE_LOW_CYC - 1)) begin
          // Both strobes rise together; address, data and select were steady all along.
          sel_n_next = 1'b1;
          wr_n_next  = 1'b1;
          cnt_next   = '0;
          state_next = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // Data held past the rising edge, then released.
        // The address stays on the pins until the next pop, so the cycle outlasts its minimum.
        oe_next    = 1'b0;
        cnt_next   = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(TURN_CYC - 1)) begin
          state_next = ST_IDLE;
        end
      end
      ST_RD_TURN: begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(CYCLE_CYC)) begin
          state_next = ST_RD_WAIT;
        end
      end
      ST_RD_WAIT: begin
        // Synchronised data has had two more edges to settle.
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_W'(CYCLE_CYC + 2)) begin
          rdata_next   = dq_sync_reg;
          rdv_next     = 1'b1;
          sel_n_next   = 1'b1;
          outen_n_next = 1'b1;
          cnt_next     = '0;
          state_next   = ST_RECOVER;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= '0;
      addr_reg    <= '0;
      wdata_reg   <= '0;
      sel_n_reg   <= SEL_N_RST;
      wr_n_reg    <= WR_N_RST;
      outen_n_reg <= OUTEN_N_RST;
      oe_reg      <= 1'b0;
      rdv_reg     <= 1'b0;
      rdata_reg   <= '0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      sel_n_reg   <= sel_n_next;
      wr_n_reg    <= wr_n_next;
      outen_n_reg <= outen_n_next;
      oe_reg      <= oe_next;
      rdv_reg     <= rdv_next;
      rdata_reg   <= rdata_next;
    end
  end

  // Cycles the write strobe has been low, saturating; only the pulse check reads it.
  logic [CNT_W-1:0] wr_low_cnt_reg;
  logic [CNT_W-1:0] wr_low_cnt_next;

  // Counts up while the strobe is low and clears once it is high again.
  always_comb begin
    wr_low_cnt_next = '0;
    if (!wr_n_reg) begin
      wr_low_cnt_next = (wr_low_cnt_reg == '1) ? wr_low_cnt_reg : wr_low_cnt_reg + 1'b1;
    end
  end

  // Strobe-low counter register.
  always_ff @(posedge CLK) begin
    if (RST) begin
      wr_low_cnt_reg <= '0;
    end else begin
      wr_low_cnt_reg <= wr_low_cnt_next;
    end
  end

  // Pins and answer come straight from registers.
  assign MEM_ADDR    = addr_reg;
  assign MEM_SEL_N   = sel_n_reg;
  assign MEM_WR_N    = wr_n_reg;
  assign MEM_OUTEN_N = outen_n_reg;
  assign MEM_DQ_OUT  = wdata_reg;
  assign MEM_DQ_OE   = oe_reg;
  assign RD_VALID    = rdv_reg;
  assign RD_DATA     = rdata_reg;

  // Pin-level checks of the write and read sequences.
  a_strobe_overlap: assert property (@(posedge CLK) disable iff (RST)
    $fell(MEM_WR_N) |-> !MEM_SEL_N && $fell(MEM_SEL_N))
    else $error("write strobe fell without select falling with it");

  a_addr_stable_write: assert property (@(posedge CLK) disable iff (RST)
    !MEM_WR_N |-> $stable(MEM_ADDR))
    else $error("address moved during write");

  a_addr_before_end: assert property (@(posedge CLK) disable iff (RST)
    $rose(MEM_WR_N) |-> $past(MEM_ADDR) == $past(MEM_ADDR, 2))
    else $error("address moved in the cycle before the write ended");

  a_strobe_low_width: assert property (@(posedge CLK) disable iff (RST)
    $rose(MEM_WR_N) |-> wr_low_cnt_reg >= CNT_W'(WRITE_LOW_CYC)
      && wr_low_cnt_reg >= CNT_W'(SELECT_LOW_CYC))
    else $error("write pulse too short");

  a_data_lead_rise: assert property (@(posedge CLK) disable iff (RST)
    $rose(MEM_WR_N) |-> MEM_DQ_OE && $stable(MEM_DQ_OUT) && $past(MEM_DQ_OE))
    else $error("write data not driven before strobe rise");

  a_select_ends_together: assert property (@(posedge CLK) disable iff (RST)
    $rose(MEM_WR_N) |-> $rose(MEM_SEL_N))
    else $error("select and strobe did not end together");

  a_no_contention: assert property (@(posedge CLK) disable iff (RST)
    MEM_DQ_OE |-> MEM_OUTEN_N)
    else $error("host drives bus while output enable is low");

  a_read_strobe_high: assert property (@(posedge CLK) disable iff (RST)
    !MEM_OUTEN_N |-> MEM_WR_N)
    else $error("write strobe low during read");

  a_read_answer_time: assert property (@(posedge CLK) disable iff (RST)
    $fell(MEM_OUTEN_N) |-> !MEM_OUTEN_N [*4])
    else $error("output enable released too soon");

  a_write_data_first: assert property (@(posedge CLK) disable iff (RST)
    $fell(MEM_WR_N) |-> $past(MEM_DQ_OE))
    else $error("write strobe fell before the data was driven");

  a_data_release: assert property (@(posedge CLK) disable iff (RST)
    $rose(MEM_WR_N) |=> !MEM_DQ_OE)
    else $error("write data still driven after recovery");

  a_idle_pins: assert property (@(posedge CLK) disable iff (RST)
    state_reg == ST_IDLE |-> MEM_WR_N && MEM_SEL_N && !MEM_DQ_OE)
    else $error("pins not released while idle");

  a_read_pulse: assert property (@(posedge CLK) disable iff (RST)
    RD_VALID |=> !RD_VALID)
    else $error("read answer longer than one cycle");

  a_read_under_select: assert property (@(posedge CLK) disable iff (RST)
    RD_VALID |-> $rose(MEM_SEL_N) && $rose(MEM_OUTEN_N))
    else $error("read answer taken without select and enable low");
endmodule

/* design/sync_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module sync_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("sync_fifo depth must be a power of two of at least two");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      wr_ptr_next;
  logic [AW:0]      rd_ptr_reg;
  logic [AW:0]      rd_ptr_next;
  logic             push;
  logic             pop;

  // Full and empty come from the pointer difference.
  always_comb begin
    in_ready    = (wr_ptr_reg - rd_ptr_reg) != (AW + 1)'(DEPTH);
    out_valid   = wr_ptr_reg != rd_ptr_reg;
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    wr_ptr_next = wr_ptr_reg + (AW + 1)'(push);
    rd_ptr_next = rd_ptr_reg + (AW + 1)'(pop);
    out_data    = mem[rd_ptr_reg[AW-1:0]];
  end

  // Pointers and storage.
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  a_fifo_no_overrun: assert property (@(posedge clk) disable iff (rst)
    (wr_ptr_reg - rd_ptr_reg) <= (AW + 1)'(DEPTH))
    else $error("FIFO holds more words than its depth");
endmodule

/* shared/sram_host_pkg.sv */
// Package with pin widths, timing figures and cycle counts for the SRAM write host.
package sram_host_pkg;

  // Pin widths of the memory.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 4;

  // Clock period in picoseconds (20 MHz).
  localparam int CLK_PS = 50000;

  // Timing figures in picoseconds, slowest speed grade.
  localparam int WRITE_CYCLE_PS   = 12000;
  localparam int ADDR_TO_END_PS   = 10000;
  localparam int DATA_LEAD_PS     = 6000;
  localparam int SELECT_LOW_PS    = 9000;
  localparam int STROBE_FLOAT_PS  = 6000;
  localparam int STROBE_REDRIVE_PS = 3000;

  // Least times round up to whole cycles, never below one.
  function automatic int min_cycles(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int WRITE_LOW_CYC  = min_cycles(ADDR_TO_END_PS);
  localparam int DATA_LEAD_CYC  = min_cycles(DATA_LEAD_PS);
  localparam int SELECT_LOW_CYC = min_cycles(SELECT_LOW_PS);
  localparam int CYCLE_CYC      = min_cycles(WRITE_CYCLE_PS);
  localparam int TURN_CYC       = min_cycles(STROBE_FLOAT_PS);

  // Width of the step counter.
  localparam int CNT_W = 4;

  // Reset levels of the strobes (all inactive high).
  localparam logic SEL_N_RST   = 1'b1;
  localparam logic WR_N_RST    = 1'b1;
  localparam logic OUTEN_N_RST = 1'b1;

  // Host sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RECOVER,
    ST_RD_TURN,
    ST_RD_WAIT
  } host_state_t;

endpackage

/* sim/sram_model.sv */
// Behavioural model of the 64K by 4 static RAM seen from its pins.
`timescale 1ns/1ns
module sram_model
  import sram_host_pkg::*;
(
  // Address and active-low strobes.
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              sel_n,
  input  wire logic              outen_n,
  input  wire logic              wr_n,
  // Host side of the two-way data pins.
  input  wire logic [DATA_W-1:0] dq_host,
  input  wire logic              dq_oe,
  // Resolved data pins and a flag for two drivers at once.
  output logic      [DATA_W-1:0] dq_wire,
  output logic                   clash
);
  logic [DATA_W-1:0] mem [0:65535];
  logic [DATA_W-1:0] last;
  logic              drv;

  // The memory drives only when selected, not writing and enabled; it turns on 3 ns late.
  assign #(3, 0) drv = !sel_n && wr_n && !outen_n;

  // Storage happens only while select and write strobe overlap low.
  always @* begin
    if (!sel_n && !wr_n) begin
      mem[addr] = dq_host;
    end
  end

  // Remember the last driven level so that a floating bus shows its inverse.
  always @(dq_oe or drv or dq_host or addr) begin
    if (dq_oe) begin
      last = dq_host;
    end else if (drv) begin
      last = mem[addr];
    end
  end

  // Wire level from both parties' enables.
  assign dq_wire = dq_oe ? dq_host : (drv ? mem[addr] : ~last);
  assign clash   = dq_oe && drv;

  initial last = '0;
endmodule

/* sim/sram_write_host_tb.sv */
// Self-checking bench for the SRAM write host against a behavioural memory.
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %h expected %h", $time, g, e); end end
module sram_write_host_tb
  import sram_host_pkg::*;
;
  logic              CLK, RST, REQ_VALID, REQ_READY, REQ_WRITE, RD_VALID;
  logic              MEM_SEL_N, MEM_OUTEN_N, MEM_WR_N, MEM_DQ_OE, clash, prev_wr;
  logic [ADDR_W-1:0] REQ_ADDR, MEM_ADDR, prev_addr, a_v;
  logic [DATA_W-1:0] REQ_WDATA, RD_DATA, MEM_DQ_OUT, MEM_DQ_IN, prev_dq, exp_v;
  logic [DATA_W-1:0] ref_mem [int];
  logic [DATA_W-1:0] exp_q [$];
  logic [ADDR_W-1:0] used_q [$];
  int                n_mismatch, n_tests, n_wr, n_strobe, n_refused, seed, i;

  // Design and memory model.
  sram_write_host u_sram_write_host (.CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA),
    .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .MEM_ADDR(MEM_ADDR), .MEM_SEL_N(MEM_SEL_N),
    .MEM_OUTEN_N(MEM_OUTEN_N), .MEM_WR_N(MEM_WR_N), .MEM_DQ_OUT(MEM_DQ_OUT),
    .MEM_DQ_OE(MEM_DQ_OE), .MEM_DQ_IN(MEM_DQ_IN));
  sram_model u_sram_model (.addr(MEM_ADDR), .sel_n(MEM_SEL_N), .outen_n(MEM_OUTEN_N),
    .wr_n(MEM_WR_N), .dq_host(MEM_DQ_OUT), .dq_oe(MEM_DQ_OE), .dq_wire(MEM_DQ_IN),
    .clash(clash));

  // A 50 ns clock.
  initial CLK = 1'b0;
  always #25 CLK = ~CLK;

  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Offers one request at a rising edge and holds it until the FIFO takes it.
  task automatic send(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int k;
    REQ_VALID <= 1'b1;
    REQ_WRITE <= w;
    REQ_ADDR  <= a;
    REQ_WDATA <= d;
    if (w) begin
      ref_mem[a] = d;
      n_wr++;
      used_q.push_back(a);
    end else begin
      exp_q.push_back(ref_mem[a]);
    end
    for (k = 0; k < 100; k++) begin
      @(negedge CLK);
      if (REQ_READY === 1'b1) break;
      n_refused++;
    end
    if (k == 100) begin
      n_mismatch++;
      $display("[ERR] %0t request never taken", $time);
      summarize();
    end
    @(posedge CLK);
  endtask

  // Stops offering and waits until every write and read has finished.
  task automatic drain(input string name);
    int k;
    REQ_VALID <= 1'b0;
    for (k = 0; k < 2000 && (exp_q.size() != 0 || n_strobe != n_wr); k++) @(posedge CLK);
    if (k == 2000) begin
      n_mismatch++;
      $display("[ERR] %0t traffic did not drain", $time);
      summarize();
    end
    repeat (8) @(posedge CLK);
    `CHK(n_strobe, n_wr)
    $display("test %s done: %0d checks, %0d mismatches", name, n_tests, n_mismatch);
  endtask

  // Pin monitor: read answers, write strobes, turnaround and contention.
  always @(posedge CLK) begin
    prev_wr   <= MEM_WR_N;
    prev_addr <= MEM_ADDR;
    prev_dq   <= MEM_DQ_OUT;
    if (!RST) begin
      if (RD_VALID === 1'b1) begin
        // Pop once, so that a mismatch report does not take a second word.
        exp_v = exp_q.pop_front();
        `CHK(RD_DATA, exp_v)
      end
      if (MEM_WR_N === 1'b0 && prev_wr === 1'b1) begin
        n_strobe++;
        `CHK({MEM_SEL_N, MEM_OUTEN_N, MEM_DQ_OE}, 3'b011)
        `CHK(MEM_ADDR, prev_addr)
        `CHK(MEM_DQ_OUT, prev_dq)
      end
      if (MEM_OUTEN_N === 1'b0) `CHK(MEM_WR_N, 1'b1)
      if (clash === 1'b1) `CHK(clash, 1'b0)
    end
  end

  // Main sequence.
  initial begin
    seed      = 40594;
    RST       = 1'b1;
    REQ_VALID = 1'b0;
    REQ_WRITE = 1'b0;
    REQ_ADDR  = 16'h0000;
    REQ_WDATA = 4'h0;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    @(negedge CLK);
    `CHK({MEM_SEL_N, MEM_WR_N, MEM_OUTEN_N, MEM_DQ_OE, RD_VALID}, 5'b11100)
    `CHK(REQ_READY, 1'b1)
    @(posedge CLK);
    // Lowest and highest word, written and read back to back.
    send(1'b1, 16'h0000, 4'hA);
    send(1'b1, 16'hFFFF, 4'h5);
    send(1'b0, 16'hFFFF, 4'h0);
    send(1'b0, 16'h0000, 4'h0);
    drain("boundary");
    // Sixty random mixed requests offered back to back, enough that the FIFO refuses some.
    for (i = 0; i < 60; i++) begin
      if (($random(seed) & 1) != 0) begin
        a_v = $random(seed);
        send(1'b1, a_v, 4'($random(seed)));
      end else begin
        send(1'b0, used_q[$unsigned($random(seed)) % used_q.size()], 4'h0);
      end
    end
    drain("random");
    `CHK(n_refused > 0, 1'b1)
    // Read back every word written so far.
    for (i = 0; i < used_q.size(); i++) send(1'b0, used_q[i], 4'h0);
    drain("readback");
    summarize();
  end
endmodule
